// ---- common/pcerr_pkg.sv ----
package pcerr_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int HDR_W  = 48;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_SEV   = 8'h04;
   localparam logic [7:0] REG_UMASK = 8'h08;
   localparam logic [7:0] REG_CMASK = 8'h0c;
   localparam logic [7:0] REG_STAT  = 8'h10;
   localparam logic [7:0] REG_LEVEL = 8'h14;

   // Control register bit positions
   localparam int CTRL_W       = 5;
   localparam int CTRL_AER     = 0;
   localparam int CTRL_COR_EN  = 1;
   localparam int CTRL_NF_EN   = 2;
   localparam int CTRL_FAT_EN  = 3;
   localparam int CTRL_SERR_EN = 4;

   // Uncorrectable report index, shared by severity, mask and status
   localparam int UE_W     = 9;
   localparam int UE_UR    = 0;
   localparam int UE_CA    = 1;
   localparam int UE_CTO   = 2;
   localparam int UE_ECRC  = 3;
   localparam int UE_MAL   = 4;
   localparam int UE_MCB   = 5;
   localparam int UE_POIS  = 6;
   localparam int UE_UNEXP = 7;
   localparam int UE_ATOM  = 8;

   // Correctable index; status holds these above the UE bits
   localparam int CE_W   = 4;
   localparam int CE_COR = 0;
   localparam int CE_ICR = 1;
   localparam int CE_ADV = 2;
   localparam int CE_HLO = 3;
   localparam int STAT_W = UE_W + CE_W;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
   localparam logic [UE_W-1:0]   SEV_RST   = 9'h010;
   localparam logic [UE_W-1:0]   UMASK_RST = 9'h000;
   localparam logic [CE_W-1:0]   CMASK_RST = 4'h0;

   // Completion status codes
   localparam logic [2:0] CPL_UR = 3'h1;
   localparam logic [2:0] CPL_CA = 3'h4;

   typedef enum logic [1:0] {
      MSG_NONE  = 2'b00,
      MSG_COR   = 2'b01,
      MSG_NF    = 2'b10,
      MSG_FATAL = 2'b11
   } pcerr_msg_e;
endpackage : pcerr_pkg

// ---- design/pcerr_classify.sv ----
// Combinational outcome of one report; reports assumed one-hot
module pcerr_classify
   import pcerr_pkg::*;
(
   input  wire logic [UE_W-1:0]   ue,
   input  wire logic              cor,
   input  wire logic              icor,
   input  wire logic              hlo,
   input  wire logic              posted,
   input  wire logic              no_rec,
   input  wire logic [CTRL_W-1:0] ctrl,
   input  wire logic [UE_W-1:0]   sev,
   input  wire logic [UE_W-1:0]   umask,
   input  wire logic [CE_W-1:0]   cmask,
   output pcerr_msg_e             kind,
   output logic      [STAT_W-1:0] stat_set,
   output logic                   cpl_req,
   output logic      [2:0]        cpl_status
);
   wire aer    = ctrl[CTRL_AER];
   wire ur_np  = ue[UE_UR] & ~posted;
   wire ca_np  = ue[UE_CA] & ~posted;
   // Masks only matter with AER on
   wire [UE_W-1:0] um = aer ? umask : '0;
   wire [CE_W-1:0] cm = aer ? cmask : '0;

   // Advisory class: silent without AER, correctable with it
   wire adv = ue[UE_UNEXP] | ue[UE_ATOM] | ur_np
            | (ue[UE_CTO] & ~no_rec) | (ue[UE_POIS] & ~no_rec)
            | (ca_np & aer);
   wire unc = (ue[UE_UR] & posted) | (ue[UE_CA] & posted)
            | (ue[UE_CTO] & no_rec) | (ue[UE_POIS] & no_rec)
            | ue[UE_ECRC] | ue[UE_MAL] | ue[UE_MCB]
            | (ca_np & ~aer);
   wire hlo_in = hlo & aer;
   wire cor_hit = (cor & ~cm[CE_COR]) | (icor & ~cm[CE_ICR])
                | (hlo_in & ~cm[CE_HLO]);
   wire adv_hit = adv & aer & ~cm[CE_ADV];
   wire unc_hit = unc & ~|(ue & um);
   // Severity picks the type with AER; malformed is fatal without it
   wire fatal = aer ? |(ue & sev) : ue[UE_MAL];

   wire en_cor = ctrl[CTRL_COR_EN];
   wire en_nf  = ctrl[CTRL_NF_EN] | ctrl[CTRL_SERR_EN];
   wire en_fat = ctrl[CTRL_FAT_EN] | ctrl[CTRL_SERR_EN];

   // Uncorrectable outranks advisory and correctable, which both give a correctable message
   assign kind = unc_hit ? (fatal ? (en_fat ? MSG_FATAL : MSG_NONE)
                                  : (en_nf ? MSG_NF : MSG_NONE))
               : ((adv_hit | cor_hit) && en_cor) ? MSG_COR
               : MSG_NONE;
   // Status bits do not depend on any message enable; header log overflow needs AER
   assign stat_set   = {hlo_in, adv, icor, cor, ue};
   assign cpl_req    = ur_np | ca_np;
   assign cpl_status = ca_np ? CPL_CA : CPL_UR;
endmodule : pcerr_classify

// ---- design/pcerr_front.sv ----
// Operation
// - Timeout with no-recovery and AER: non-fatal or fatal by severity.
// - No AER: timeout/poisoned no-recovery, ECRC, multicast block give non-fatal.
// - AER: ECRC, malformed, multicast, poisoned no-recovery pick type by severity.
// - No AER: malformed report gives a fatal message if enabled.
// - Unexpected, atomic blocked, poisoned recoverable: silent without AER, else correctable.
// - Header log overflow is a correctable cause only with AER on.
// - Supplied header builds the non-successful completion.
// - Posted error: non-fatal message if enabled, never a completion. With AER the code takes the type from severity.
// - Completion-ready drops when no more non-posted reports fit.
// - Cleared enable bits suppress the message.
// - Status bits set on every report (header log overflow only with AER), even with messages off.
// - With AER, severity and masks decide message and type.
// - Non-posted UR: UR completion, plus correctable message under AER.
// - Non-posted abort: abort completion plus a message if enabled.
//
// The implementer's own choices: the address-and-strobe port and the address map.
module pcerr_front
   import pcerr_pkg::*;
#(
   parameter int DEPTH = 4
)(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              rpt_unsupported_request,
   input  wire logic              rpt_cpl_abort,
   input  wire logic              rpt_cpl_timeout,
   input  wire logic              rpt_ecrc,
   input  wire logic              rpt_malformed,
   input  wire logic              rpt_multicast_block,
   input  wire logic              rpt_poisoned,
   input  wire logic              rpt_cpl_unexpect,
   input  wire logic              rpt_atomic_egress_block,
   input  wire logic              rpt_cor,
   input  wire logic              rpt_internal_cor,
   input  wire logic              rpt_posted,
   input  wire logic              rpt_no_recovery,
   input  wire logic [HDR_W-1:0]  rpt_cpl_header,
   input  wire logic              hdr_log_overflow,
   output logic                   rpt_cpl_ready,
   output logic                   cpl_valid,
   output logic      [2:0]        cpl_status,
   output logic      [HDR_W-1:0]  cpl_header,
   input  wire logic              cpl_taken,
   output logic                   msg_valid,
   output pcerr_msg_e             msg_kind
);
   localparam int AW = $clog2(DEPTH);
   localparam int EW = HDR_W + 3;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   // Software state
   logic [CTRL_W-1:0] ctrl;
   logic [UE_W-1:0]   sev;
   logic [UE_W-1:0]   umask;
   logic [CE_W-1:0]   cmask;
   logic [STAT_W-1:0] stat;

   // Completion queue state
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   level;
   logic [EW-1:0] head;

   // Classifier outputs
   pcerr_msg_e        kind;
   logic [STAT_W-1:0] stat_set;
   logic              cpl_req;
   logic [2:0]        new_status;

   wire [UE_W-1:0] ue_vec = {rpt_atomic_egress_block, rpt_cpl_unexpect,
                             rpt_poisoned, rpt_multicast_block,
                             rpt_malformed, rpt_ecrc, rpt_cpl_timeout,
                             rpt_cpl_abort, rpt_unsupported_request};

   pcerr_classify u_class (
      .ue         (ue_vec),
      .cor        (rpt_cor),
      .icor       (rpt_internal_cor),
      .hlo        (hdr_log_overflow),
      .posted     (rpt_posted),
      .no_rec     (rpt_no_recovery),
      .ctrl       (ctrl),
      .sev        (sev),
      .umask      (umask),
      .cmask      (cmask),
      .kind       (kind),
      .stat_set   (stat_set),
      .cpl_req    (cpl_req),
      .cpl_status (new_status)
   );

   // Register decode
   wire wr_ctrl  = reg_wr && reg_addr == REG_CTRL;
   wire wr_sev   = reg_wr && reg_addr == REG_SEV;
   wire wr_umask = reg_wr && reg_addr == REG_UMASK;
   wire wr_cmask = reg_wr && reg_addr == REG_CMASK;
   wire wr_stat  = reg_wr && reg_addr == REG_STAT;

   // Write-one-to-clear; a new report in the same cycle wins
   wire [STAT_W-1:0] stat_clr  = wr_stat ? reg_wdata[STAT_W-1:0] : '0;
   wire [STAT_W-1:0] next_stat = (stat & ~stat_clr) | stat_set;

   // Unmapped addresses read as zero
   wire [DATA_W-1:0] rd_mux =
        reg_addr == REG_CTRL  ? DATA_W'(ctrl)  :
        reg_addr == REG_SEV   ? DATA_W'(sev)   :
        reg_addr == REG_UMASK ? DATA_W'(umask) :
        reg_addr == REG_CMASK ? DATA_W'(cmask) :
        reg_addr == REG_STAT  ? DATA_W'(stat)  :
        reg_addr == REG_LEVEL ? DATA_W'(level) : '0;

   // Configuration registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl  <= CTRL_RST;
         sev   <= SEV_RST;
         umask <= UMASK_RST;
         cmask <= CMASK_RST;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= reg_wdata[CTRL_W-1:0];
         if (wr_sev)
            sev <= reg_wdata[UE_W-1:0];
         if (wr_umask)
            umask <= reg_wdata[UE_W-1:0];
         if (wr_cmask)
            cmask <= reg_wdata[CE_W-1:0];
      end
   end

   // Status and read data
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         stat      <= '0;
         reg_rdata <= '0;
      end
      else
      begin
         stat      <= next_stat;
         reg_rdata <= reg_rd ? rd_mux : '0;
      end
   end

   // Queue control; a completion arriving while full is dropped,
   // since the user is bound to hold off while ready is low
   assign rpt_cpl_ready = level != FULL;
   wire push = cpl_req && rpt_cpl_ready;
   wire pop  = cpl_valid && cpl_taken;
   wire [AW:0]   next_level  = level + (AW + 1)'(push) - (AW + 1)'(pop);
   wire [AW-1:0] next_rd_ptr = rd_ptr + AW'(pop);

   // Pointers wrap naturally; depth must be a power of two
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         level     <= '0;
         cpl_valid <= 1'b0;
      end
      else
      begin
         wr_ptr    <= wr_ptr + AW'(push);
         rd_ptr    <= next_rd_ptr;
         level     <= next_level;
         cpl_valid <= next_level != '0;
      end
   end

   // Head entry is always the oldest accepted report
   pcerr_mem #(
      .W     (EW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk   (clk),
      .we    (push),
      .waddr (wr_ptr),
      .wdata ({new_status, rpt_cpl_header}),
      .raddr (next_rd_ptr),
      .rdata (head)
   );

   assign cpl_status = head[EW-1:HDR_W];
   assign cpl_header = head[HDR_W-1:0];

   // Message strobe, one cycle after the report
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         msg_valid <= 1'b0;
         msg_kind  <= MSG_NONE;
      end
      else
      begin
         msg_valid <= kind != MSG_NONE;
         msg_kind  <= kind;
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   wire aer    = ctrl[CTRL_AER];
   wire en_fat = ctrl[CTRL_FAT_EN] | ctrl[CTRL_SERR_EN];
   wire en_nf  = ctrl[CTRL_NF_EN] | ctrl[CTRL_SERR_EN];

   AST_FULL_NOT_READY:
      assert property (push && !pop && level == (AW + 1)'(DEPTH - 1)
                       |=> !rpt_cpl_ready)
      else $error("ready high after queue filled");

   AST_MAL_FATAL:
      assert property (rpt_malformed && !aer && en_fat
                       |=> msg_valid && msg_kind == MSG_FATAL)
      else $error("malformed without AER not fatal");

   AST_UNEXP_SILENT:
      assert property (rpt_cpl_unexpect && !aer |=> !msg_valid)
      else $error("advisory report sent a message");

   AST_CTO_SEVERITY:
      assert property (rpt_cpl_timeout && rpt_no_recovery && aer
                       && !umask[UE_CTO] && sev[UE_CTO] && en_fat
                       |=> msg_kind == MSG_FATAL)
      else $error("timeout severity not honoured");

   AST_ENABLES_OFF:
      assert property (ctrl[CTRL_SERR_EN:CTRL_COR_EN] == '0 |=> !msg_valid)
      else $error("message sent with enables cleared");

   AST_STATUS_SET:
      assert property (rpt_ecrc |=> stat[UE_ECRC])
      else $error("status bit not set");

   AST_POSTED_NO_CPL:
      assert property (rpt_unsupported_request && rpt_posted && !pop
                       |=> level == $past(level))
      else $error("posted report queued a completion");

   AST_CPL_HEADER:
      assert property (push && level == '0
                       |=> cpl_valid && cpl_header == $past(rpt_cpl_header))
      else $error("completion header lost");

   AST_COR_MSG:
      assert property (rpt_cor && !aer && ctrl[CTRL_COR_EN]
                       |=> msg_valid && msg_kind == MSG_COR)
      else $error("correctable message missing");

   AST_POSTED_NF:
      assert property (rpt_unsupported_request && rpt_posted && !aer && en_nf
                       |=> msg_valid && msg_kind == MSG_NF)
      else $error("posted report without non-fatal message");

   AST_NP_UR_CPL:
      assert property (rpt_unsupported_request && !rpt_posted && level == '0
                       |=> cpl_valid && cpl_status == CPL_UR)
      else $error("unsupported request completion missing");

   AST_NP_CA_CPL:
      assert property (rpt_cpl_abort && !rpt_posted && level == '0
                       |=> cpl_valid && cpl_status == CPL_CA)
      else $error("completer abort completion missing");

   AST_POP_LEVEL:
      assert property (pop && !push |=> level == $past(level) - (AW + 1)'(1))
      else $error("taken completion not removed");

   AST_HLO_NO_AER:
      assert property (hdr_log_overflow && !aer && !stat[UE_W + CE_HLO]
                       |=> !stat[UE_W + CE_HLO])
      else $error("header log overflow counted without AER");

   AST_MASKED_SILENT:
      assert property (rpt_ecrc && aer && umask[UE_ECRC] |=> !msg_valid)
      else $error("masked report sent a message");
endmodule : pcerr_front

// ---- design/pcerr_mem.sv ----
// Completion store; read data registered, write-through on address match
module pcerr_mem
   import pcerr_pkg::*;
#(
   parameter int W     = 51,
   parameter int DEPTH = 4,
   parameter int AW    = 2
)(
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [DEPTH];

   // Storage array
   always_ff @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end

   // Bypass keeps a push into an empty store visible next cycle
   always_ff @(posedge clk)
   begin
      if (we && waddr == raddr)
         rdata <= wdata;
      else
         rdata <= mem[raddr];
   end
endmodule : pcerr_mem

// ---- testbench/pcerr_front_tb_top.sv ----
module pcerr_front_tb_top
   import pcerr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, cpl_taken = 0, take_en = 0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
   logic [11:0] rpt_vec;
   logic rpt_posted, rpt_no_recovery, rpt_cpl_ready, cpl_valid, msg_valid, rd_pend = 0;
   logic [HDR_W-1:0] rpt_cpl_header, cpl_header;
   logic [2:0] cpl_status;
   pcerr_msg_e msg_kind;
   logic [CTRL_W-1:0] ctrl_sh;
   logic [UE_W-1:0] sev_sh, umask_sh;
   logic [CE_W-1:0] cmask_sh;
   pcerr_msg_e msg_q[$];
   logic [50:0] cpl_q[$];
   logic [63:0] rd_q[$];
   logic [63:0] rd_e;
   logic [4:0] ctrl_tab [6] = '{5'h1e, 5'h0c, 5'h1f, 5'h0f, 5'h01, 5'h00};
   int errors = 0, tests_run = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   pcerr_front #(.DEPTH(2)) DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rpt_unsupported_request(rpt_vec[0]), .rpt_cpl_abort(rpt_vec[1]), .rpt_cpl_timeout(rpt_vec[2]),
      .rpt_ecrc(rpt_vec[3]), .rpt_malformed(rpt_vec[4]), .rpt_multicast_block(rpt_vec[5]),
      .rpt_poisoned(rpt_vec[6]), .rpt_cpl_unexpect(rpt_vec[7]), .rpt_atomic_egress_block(rpt_vec[8]),
      .rpt_cor(rpt_vec[9]), .rpt_internal_cor(rpt_vec[10]), .rpt_posted(rpt_posted),
      .rpt_no_recovery(rpt_no_recovery), .rpt_cpl_header(rpt_cpl_header),
      .hdr_log_overflow(rpt_vec[11]), .rpt_cpl_ready(rpt_cpl_ready), .cpl_valid(cpl_valid),
      .cpl_status(cpl_status), .cpl_header(cpl_header), .cpl_taken(cpl_taken),
      .msg_valid(msg_valid), .msg_kind(msg_kind));

   pcerr_user_model u_user (.clk(clk), .rpt_cpl_ready(rpt_cpl_ready), .rpt_vec(rpt_vec),
      .rpt_posted(rpt_posted), .rpt_no_recovery(rpt_no_recovery), .rpt_cpl_header(rpt_cpl_header));

   task automatic check(input string name, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (e !== g)
      begin
         $display("unexpected %s: expected %h seen %h", name, e, g);
         errors++;
      end
   endtask : check

   task automatic end_sim();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // Outcome of one report under the shadowed settings
   function automatic pcerr_msg_e exp_kind(input int idx, input logic p, input logic nr);
      logic aer, adv, msk;
      pcerr_msg_e k;
      aer = ctrl_sh[CTRL_AER];
      adv = idx inside {UE_UNEXP, UE_ATOM} || (idx inside {UE_CTO, UE_POIS} && !nr) || (idx < 2 && !p);
      if (idx >= 9)
      begin
         k = (idx < 11 || aer) ? MSG_COR : MSG_NONE;
         msk = cmask_sh[(idx == 11) ? CE_HLO : idx - 9];
      end
      else if (adv)
      begin
         k = aer ? MSG_COR : ((idx == UE_CA) ? MSG_NF : MSG_NONE);
         msk = cmask_sh[CE_ADV];
      end
      else
      begin
         k = (aer ? sev_sh[idx] : idx == UE_MAL) ? MSG_FATAL : MSG_NF;
         msk = umask_sh[idx];
      end
      if (aer && msk)
         k = MSG_NONE;
      if ((k == MSG_COR && !ctrl_sh[CTRL_COR_EN]) ||
          (k == MSG_NF && !(ctrl_sh[CTRL_NF_EN] | ctrl_sh[CTRL_SERR_EN])) ||
          (k == MSG_FATAL && !(ctrl_sh[CTRL_FAT_EN] | ctrl_sh[CTRL_SERR_EN])))
         k = MSG_NONE;
      return k;
   endfunction : exp_kind

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_q.push_back({m, e});
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic cfg(input logic [4:0] c, input logic [8:0] s, input logic [8:0] u, input logic [3:0] m);
      ctrl_sh = c;
      sev_sh = s;
      umask_sh = u;
      cmask_sh = m;
      wr(REG_CTRL, 32'(c));
      wr(REG_SEV, 32'(s));
      wr(REG_UMASK, 32'(u));
      wr(REG_CMASK, 32'(m));
   endtask : cfg

   // Notes the expected message and completion, then has the model report
   task automatic rpt(input int idx, input logic p, input logic nr);
      logic [HDR_W-1:0] hdr;
      pcerr_msg_e k;
      logic ok;
      hdr = HDR_W'({$urandom, $urandom});
      k = exp_kind(idx, p, nr);
      if (k != MSG_NONE)
         msg_q.push_back(k);
      if (idx < 2 && !p)
         cpl_q.push_back({(idx == 0) ? CPL_UR : CPL_CA, hdr});
      u_user.report(idx, p, nr, hdr, ok);
      if (!ok)
         check("ready wait", 0, 1);
   endtask : rpt

   // Consumer stalls at random once taking is enabled
   always @(posedge clk)
      cpl_taken <= take_en & 1'($urandom);

   // Oldest note against each result as it appears
   always @(posedge clk)
   begin
      rd_pend <= reg_rd;
      if (rd_pend)
      begin
         rd_e = rd_q.pop_front();
         check("reg_rdata", rd_e[31:0] & rd_e[63:32], reg_rdata & rd_e[63:32]);
      end
      if (msg_valid === 1'b1 && msg_q.size() == 0)
         check("msg_valid", 0, 1);
      else if (msg_valid === 1'b1)
         check("msg_kind", msg_q.pop_front(), msg_kind);
      if (cpl_valid === 1'b1 && cpl_taken === 1'b1 && cpl_q.size() == 0)
         check("cpl_valid", 0, 1);
      else if (cpl_valid === 1'b1 && cpl_taken === 1'b1)
         check("cpl", cpl_q.pop_front(), {cpl_status, cpl_header});
   end

   initial
   begin
      int n;
      void'($urandom(32'hc77f));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(REG_CTRL, 32'(CTRL_RST), '1);
      rd(REG_SEV, 32'(SEV_RST), '1);
      rd(REG_UMASK, 32'(UMASK_RST), '1);
      rd(REG_CMASK, 32'(CMASK_RST), '1);
      rd(REG_LEVEL, 0, '1);
      rd(8'h18, 0, '1);
      // Status set with every message disabled, then cleared
      cfg(5'h00, 9'h000, 9'h000, 4'h0);
      rpt(UE_MAL, 1'b1, 1'b0);
      rd(REG_STAT, 32'h10, '1);
      wr(REG_STAT, 32'h1fff);
      rd(REG_STAT, 0, '1);
      // Fill the store with the consumer stalled
      cfg(5'h1e, 9'h000, 9'h000, 4'h0);
      rpt(UE_UR, 1'b0, 1'b0);
      rpt(UE_CA, 1'b0, 1'b0);
      @(negedge clk);
      check("rpt_cpl_ready", 0, rpt_cpl_ready);
      rd(REG_LEVEL, 2, '1);
      take_en = 1'b1;
      // Every report kind with both no-recovery values under each setting; posted varied for UR only, abort non-posted only
      foreach (ctrl_tab[c])
      begin
         cfg(ctrl_tab[c], 9'($urandom), 9'($urandom), 4'($urandom));
         for (int idx = 0; idx < 12; idx++)
            for (int k = 0; k < 4; k++)
               rpt(idx, (idx == 1) ? 1'b0 : ((idx == 0) ? k[0] : 1'b1), k[1]);
         wr(REG_STAT, 32'h1fff);
      end
      n = 0;
      while ((msg_q.size() || cpl_q.size() || rd_q.size()) && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 1000)
         check("drain", 0, 1);
      repeat (4) @(posedge clk);
      end_sim();
   end
endmodule : pcerr_front_tb_top

// ---- testbench/pcerr_user_model.sv ----
// Application side that reports errors on received packets
module pcerr_user_model
   import pcerr_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rpt_cpl_ready,
   output logic      [11:0]      rpt_vec,
   output logic                  rpt_posted,
   output logic                  rpt_no_recovery,
   output logic      [HDR_W-1:0] rpt_cpl_header
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels before the first report
   initial
   begin
      rpt_vec = '0;
      rpt_posted = 1'b1;
      rpt_no_recovery = 1'b0;
      rpt_cpl_header = '0;
   end

   // One report per call, then a quiet cycle
   task automatic report(input int idx, input logic p, input logic nr,
                         input logic [HDR_W-1:0] hdr, output logic ok);
      int n;
      n = 0;
      // Hold non-posted UR and abort back while the store is full
      do
      begin
         @(negedge clk);
         n++;
      end
      while (idx < 2 && !p && rpt_cpl_ready !== 1'b1 && n < 200);
      ok = (n < 200);
      if (!ok)
         return;
      @(posedge clk);
      rpt_vec <= 12'h1 << idx; // Single strobe
      rpt_posted <= p;
      rpt_no_recovery <= nr;
      rpt_cpl_header <= p ? ~rpt_cpl_header : hdr; // Header with the strobe
      @(posedge clk);
      rpt_vec <= '0;
      rpt_cpl_header <= ~hdr; // Released: no stale header left
   endtask : report
endmodule : pcerr_user_model
